// ===== rtl/pmc_clkdiv.sv
`timescale 1ns/1ps
module pmc_clkdiv (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic run_i,
    input  wire logic half_i,
    output logic      tick_o,
    output logic      per_out_o
);
    logic phase_ff;
    logic nxt_phase;
    logic nxt_tick;
    logic nxt_per_out;

    // Peripheral tick at full or half core rate
    always_comb begin
        nxt_phase  = run_i & half_i & ~phase_ff;
        nxt_tick   = run_i & (~half_i | phase_ff);
        nxt_per_out = nxt_tick ? ~per_out_o : per_out_o;
    end

    // Divider registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_ff <= 1'b0;
            tick_o   <= 1'b0;
            per_out_o <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            tick_o   <= nxt_tick;
            per_out_o <= nxt_per_out;
        end
    end
endmodule : pmc_clkdiv

// ===== rtl/pmc_ctrl.sv
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "pmc_defines.svh"
module pmc_ctrl
    import pmc_pkg::*;
#(
    parameter int STAB_CYCLES = `PMC_STAB_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        idle_exec_i,
    input  wire logic        wake_irq_i,
    input  wire logic [6:0]  strap_msel_i,
    input  wire logic        strap_bypass_i,
    input  wire logic        strap_div_in_i,
    input  wire logic        strap_sermode_i,
    input  wire logic [1:0]  strap_bmode_i,
    input  wire logic        bus_req_n_i,
    output logic             core_clk_en_o,
    output logic             periph_clk_en_o,
    output logic             pll_en_o,
    output logic             core_halt_o,
    output logic             pipe_flush_o,
    output logic             resume_o,
    output logic             periph_clock_output_o,
    output logic      [6:0]  pll_msel_o,
    output logic             pll_bypass_o,
    output logic             pll_div_in_o,
    output logic             stack_reset_o,
    output logic             irq_mask_all_o,
    output logic             start_o,
    output logic      [23:0] start_addr_o,
    output logic      [2:0]  boot_mode_o,
    output logic             serial_select_o,
    output logic             clock_ready_o
);
    //--------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------
    localparam int CW = $clog2(STAB_CYCLES + 1);

    pmc_strap_t             strap_raw;
    pmc_strap_t             strap_sync;
    pmc_strap_t             strap_ff;
    pmc_strap_t             nxt_strap;
    pmc_pllcfg_t            pll_ff;
    pmc_pllcfg_t            nxt_pll;
    logic                   sermode_ff;
    logic                   nxt_sermode;
    logic [CW-1:0]          stab_cnt_ff;
    logic [CW-1:0]          nxt_stab_cnt;
    logic                   ready_ff;
    logic                   nxt_ready;
    logic                   started_ff;
    logic                   nxt_started;
    logic                   start_ff;
    logic                   nxt_start;
    logic [23:0]            addr_ff;
    logic [23:0]            nxt_addr;
    logic                   capture;
    pmc_state_t             state_ff;
    pmc_state_t             nxt_state;
    logic [`PMC_LAT_W-1:0]  lat_ff;
    logic [`PMC_LAT_W-1:0]  nxt_lat;
    logic [`PMC_LAT_W-1:0]  cnt_ff;
    logic [`PMC_LAT_W-1:0]  nxt_cnt;
    logic                   lose_ff;
    logic                   nxt_lose;
    logic                   all_ff;
    logic                   nxt_all;
    logic                   resume_ff;
    logic                   nxt_resume;
    logic                   flush_ff;
    logic                   nxt_flush;
    logic                   ack_ff;
    logic                   nxt_ack;
    logic [31:0]            rdata_ff;
    logic [31:0]            nxt_rdata;
    logic                   req;
    logic                   wr_go;
    logic [31:0]            wmask;
    logic                   periph_run;

    //--------------------------------------------------------------
    // Byte-lane helpers
    //--------------------------------------------------------------
    // Expand byte enables to a bit mask
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        logic [31:0] m;
        m = '0;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{be[i]}};
        end
        return m;
    endfunction : be_mask

    // Merge write data into an old value by lane
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] m);
        return (old & ~m) | (wd & m);
    endfunction : merge

    //--------------------------------------------------------------
    // Strap synchronisers
    //--------------------------------------------------------------
    // Pins pass two flops before any logic reads them
    assign strap_raw = '{msel:    strap_msel_i,
                         bypass:  strap_bypass_i,
                         div_in:  strap_div_in_i,
                         sermode: strap_sermode_i,
                         bmode:   strap_bmode_i,
                         bus_req: ~bus_req_n_i};

    pmc_sync #(
        .W ($bits(pmc_strap_t))
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (strap_raw),
        .q_o     (strap_sync)
    );

    //--------------------------------------------------------------
    // Reset stabilisation and boot decision
    //--------------------------------------------------------------
    assign capture = ~ready_ff && (stab_cnt_ff == CW'(STAB_CYCLES - 1));

    // Count out the clock stabilisation time after reset release
    always_comb begin
        nxt_stab_cnt = stab_cnt_ff;
        nxt_ready    = ready_ff;
        nxt_strap    = strap_ff;
        nxt_started  = started_ff;
        nxt_start    = 1'b0;
        nxt_addr     = addr_ff;
        if (!ready_ff) begin
            nxt_stab_cnt = stab_cnt_ff + CW'(1);
            if (capture) begin
                nxt_ready = 1'b1;
                nxt_strap = strap_sync;
            end
        end else if (!started_ff && !strap_sync.bus_req) begin
            nxt_started = 1'b1;
            nxt_start   = 1'b1;
            if (strap_ff.bmode != 2'h0) begin
                nxt_addr = `PMC_BOOT_ROM_ADDR;
            end else begin
                nxt_addr = `PMC_EXT_START_ADDR;
            end
        end
    end

    // Stabilisation registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stab_cnt_ff <= '0;
            ready_ff    <= 1'b0;
            strap_ff    <= '0;
            started_ff  <= 1'b0;
            start_ff    <= 1'b0;
            addr_ff     <= '0;
        end else begin
            stab_cnt_ff <= nxt_stab_cnt;
            ready_ff    <= nxt_ready;
            strap_ff    <= nxt_strap;
            started_ff  <= nxt_started;
            start_ff    <= nxt_start;
            addr_ff     <= nxt_addr;
        end
    end

    //--------------------------------------------------------------
    // Power-mode state machine
    //--------------------------------------------------------------
    // Pick the mode at idle and time the wake latency
    always_comb begin
        nxt_state  = state_ff;
        nxt_lat    = lat_ff;
        nxt_cnt    = cnt_ff;
        nxt_lose   = lose_ff;
        nxt_all    = all_ff;
        nxt_resume = 1'b0;
        nxt_flush  = 1'b0;
        case (state_ff)
            ST_RUN: begin
                if (started_ff && idle_exec_i) begin
                    if (pll_ff.pll_off) begin
                        nxt_state = ST_PDALL;
                        nxt_lat   = `PMC_LAT_PDALL;
                        nxt_lose  = 1'b1;
                        nxt_all   = 1'b1;
                    end else if (pll_ff.all_stop) begin
                        nxt_state = ST_PDCP;
                        nxt_lat   = `PMC_LAT_PDCP;
                        nxt_lose  = 1'b1;
                        nxt_all   = 1'b0;
                    end else if (pll_ff.core_stop) begin
                        nxt_state = ST_PDC;
                        nxt_lat   = `PMC_LAT_PDC;
                        nxt_lose  = 1'b0;
                        nxt_all   = 1'b0;
                    end else begin
                        nxt_state = ST_IDLE;
                        nxt_lat   = `PMC_LAT_IDLE;
                        nxt_lose  = 1'b0;
                        nxt_all   = 1'b0;
                    end
                end
            end
            ST_IDLE, ST_PDC, ST_PDCP, ST_PDALL: begin
                if (wake_irq_i) begin
                    nxt_state = ST_WAKE;
                    nxt_cnt   = lat_ff;
                end
            end
            ST_WAKE: begin
                if (cnt_ff == `PMC_LAT_W'(1)) begin
                    nxt_state  = ST_RUN;
                    nxt_resume = 1'b1;
                    nxt_flush  = lose_ff;
                end else begin
                    nxt_cnt = cnt_ff - `PMC_LAT_W'(1);
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
    end

    // Power-mode registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_ff  <= ST_RUN;
            lat_ff    <= '0;
            cnt_ff    <= '0;
            lose_ff   <= 1'b0;
            all_ff    <= 1'b0;
            resume_ff <= 1'b0;
            flush_ff  <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            lat_ff    <= nxt_lat;
            cnt_ff    <= nxt_cnt;
            lose_ff   <= nxt_lose;
            all_ff    <= nxt_all;
            resume_ff <= nxt_resume;
            flush_ff  <= nxt_flush;
        end
    end

    //--------------------------------------------------------------
    // Avalon-MM slave, one wait state per access
    //--------------------------------------------------------------
    assign req   = avs_read_i | avs_write_i;
    assign wr_go = avs_write_i & ack_ff;
    assign wmask = be_mask(avs_byteenable_i);

    // Register writes, strap loads and read data
    always_comb begin
        nxt_ack    = req & ~ack_ff;
        nxt_pll    = pll_ff;
        nxt_sermode = sermode_ff;
        nxt_rdata  = rdata_ff;
        if (capture) begin
            nxt_pll.msel   = strap_sync.msel;
            nxt_pll.bypass = strap_sync.bypass;
            nxt_pll.div_in = strap_sync.div_in;
            nxt_sermode    = strap_sync.sermode;
        end else if (wr_go && avs_address_i == `PMC_OFF_PLLCFG) begin
            nxt_pll = pmc_pllcfg_t'(13'(merge({19'h0, pll_ff},
                                              avs_writedata_i,
                                              wmask)));
        end else if (wr_go && avs_address_i == `PMC_OFF_SERMODE) begin
            if (avs_byteenable_i[0]) begin
                nxt_sermode = avs_writedata_i[0];
            end
        end
        if (avs_read_i && !ack_ff) begin
            case (avs_address_i)
                `PMC_OFF_PLLCFG: nxt_rdata = {19'h0, pll_ff};
                `PMC_OFF_STATUS: begin
                    nxt_rdata = '0;
                    nxt_rdata[`PMC_STATE_LSB +: 6] = state_ff;
                    nxt_rdata[`PMC_BMODE_LSB +: 3] =
                        {strap_ff.sermode, strap_ff.bmode};
                    nxt_rdata[`PMC_READY_BIT] = ready_ff;
                    nxt_rdata[`PMC_START_BIT] = started_ff;
                end
                `PMC_OFF_SERMODE: nxt_rdata = {31'h0, sermode_ff};
                `PMC_OFF_START:  nxt_rdata = {8'h0, addr_ff};
                default:         nxt_rdata = '0;
            endcase
        end
    end

    // Bus and register file flops
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_ff    <= 1'b0;
            pll_ff    <= `PMC_PLLCFG_RST;
            sermode_ff <= 1'b0;
            rdata_ff  <= '0;
        end else begin
            ack_ff    <= nxt_ack;
            pll_ff    <= nxt_pll;
            sermode_ff <= nxt_sermode;
            rdata_ff  <= nxt_rdata;
        end
    end

    //--------------------------------------------------------------
    // Peripheral clock
    //--------------------------------------------------------------
    assign periph_run = ready_ff &
                        (state_ff == ST_RUN || state_ff == ST_IDLE ||
                         state_ff == ST_PDC ||
                         (state_ff == ST_WAKE && !all_ff));

    pmc_clkdiv u_div (
        .clk_i    (clk_i),
        .rst_n_i  (rst_n_i),
        .run_i    (periph_run),
        .half_i    (pll_ff.half_sel),
        .tick_o    (periph_clk_en_o),
        .per_out_o (periph_clock_output_o)
    );

    //--------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------
    // Clock gates from the power state
    assign core_clk_en_o  = ready_ff &
                            (state_ff == ST_RUN || state_ff == ST_IDLE ||
                             (state_ff == ST_WAKE && !all_ff));
    assign pll_en_o       = (state_ff != ST_PDALL);
    assign core_halt_o    = ~started_ff | (state_ff != ST_RUN);
    assign pipe_flush_o   = flush_ff;
    assign resume_o       = resume_ff;
    assign pll_msel_o     = pll_ff.msel;
    assign pll_bypass_o   = pll_ff.bypass;
    assign pll_div_in_o   = pll_ff.div_in;
    assign stack_reset_o  = ~started_ff;
    assign irq_mask_all_o = ~started_ff;
    assign start_o        = start_ff;
    assign start_addr_o   = addr_ff;
    assign boot_mode_o    = {strap_ff.sermode, strap_ff.bmode};
    assign serial_select_o = sermode_ff;
    assign clock_ready_o  = ready_ff;
    assign avs_readdata_o = rdata_ff;
    assign avs_waitrequest_o = req & ~ack_ff;
endmodule : pmc_ctrl

// ===== rtl/pmc_defines.svh
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

//------------------------------------------------------------------
// Timing
//------------------------------------------------------------------
`define PMC_CLK_MHZ        100
`define PMC_STAB_US        100
`define PMC_STAB_CYC       (`PMC_STAB_US * `PMC_CLK_MHZ)
`define PMC_LAT_W          10
`define PMC_LAT_IDLE       10'h002
`define PMC_LAT_PDC        10'h002
`define PMC_LAT_PDCP       10'h005
`define PMC_LAT_PDALL      10'h1f4

//------------------------------------------------------------------
// Register map and reset values
//------------------------------------------------------------------
`define PMC_OFF_PLLCFG     4'h0
`define PMC_OFF_STATUS     4'h4
`define PMC_OFF_SERMODE    4'h8
`define PMC_OFF_START      4'hc
`define PMC_PLLCFG_RST     13'h0000
`define PMC_BOOT_ROM_ADDR  24'hff0000
`define PMC_EXT_START_ADDR 24'h010000
`define PMC_STATE_LSB      0
`define PMC_BMODE_LSB      6
`define PMC_READY_BIT      9
`define PMC_START_BIT      10
`endif

// ===== rtl/pmc_pkg.sv
package pmc_pkg;
    // PLL control register layout, PLL-off in bit 0
    typedef struct packed {
        logic       bypass;
        logic       div_in;
        logic [6:0] msel;
        logic       half_sel;
        logic       all_stop;
        logic       core_stop;
        logic       pll_off;
    } pmc_pllcfg_t;

    // Strap pin group
    typedef struct packed {
        logic [6:0] msel;
        logic       bypass;
        logic       div_in;
        logic       sermode;
        logic [1:0] bmode;
        logic       bus_req;
    } pmc_strap_t;

    // Power states
    typedef enum logic [5:0] {
        ST_RUN   = 6'h01,
        ST_IDLE  = 6'h02,
        ST_PDC   = 6'h04,
        ST_PDCP  = 6'h08,
        ST_PDALL = 6'h10,
        ST_WAKE  = 6'h20
    } pmc_state_t;
endpackage : pmc_pkg

// ===== rtl/pmc_sync.sv
`timescale 1ns/1ps
module pmc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;

    // Two-stage synchroniser for pin levels
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            q_o     <= '0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule : pmc_sync

// ===== tb/pmc_core_model.sv
`timescale 1ns/1ps
module pmc_core_model (
    input  wire logic clk_i,
    output logic      idle_exec_o,
    output logic      wake_irq_o
);
    initial begin
        idle_exec_o = 1'b0;
        wake_irq_o  = 1'b0;
    end
    // Idle instruction issue, one clock wide
    task automatic do_idle();
        @(posedge clk_i);
        idle_exec_o <= 1'b1;
        @(posedge clk_i);
        idle_exec_o <= 1'b0;
    endtask : do_idle
    // Interrupt after a chosen number of quiet cycles
    task automatic do_wake(input int dly);
        repeat (dly) @(posedge clk_i);
        @(posedge clk_i);
        wake_irq_o <= 1'b1;
        @(posedge clk_i);
        wake_irq_o <= 1'b0;
    endtask : do_wake
endmodule : pmc_core_model

// ===== tb/pmc_ctrl_asserts.sv
`timescale 1ns/1ps
module pmc_ctrl_asserts #(
    parameter int STAB_CYCLES = 12
) (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        wake_irq_i,
    input wire logic [6:0]  strap_msel_i,
    input wire logic        core_clk_en_o,
    input wire logic        periph_clk_en_o,
    input wire logic        pll_en_o,
    input wire logic        core_halt_o,
    input wire logic        pipe_flush_o,
    input wire logic        resume_o,
    input wire logic [6:0]  pll_msel_o,
    input wire logic        stack_reset_o,
    input wire logic        irq_mask_all_o,
    input wire logic        start_o,
    input wire logic [23:0] start_addr_o,
    input wire logic [2:0]  boot_mode_o,
    input wire logic        clock_ready_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    //------------------------------------------------------------
    // Cycles since reset release, saturating
    //------------------------------------------------------------
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    always_comb begin
        nxt_cnt = (cnt_ff == 16'hffff) ? cnt_ff : cnt_ff + 16'h0001;
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_ff <= 16'h0000;
        else cnt_ff <= nxt_cnt;
    end

    //------------------------------------------------------------
    // Wake sequences
    //------------------------------------------------------------
    sequence s_pdall_wake;
        wake_irq_i && !pll_en_o;
    endsequence
    sequence s_resume_flush;
        resume_o && pipe_flush_o && !core_halt_o;
    endsequence

    a_pdall_wake_lat: assert property (s_pdall_wake |-> ##[501:501]
        s_resume_flush) else $error("full wake latency wrong");
    a_flush_with_res: assert property (pipe_flush_o |-> resume_o ##1
        !pipe_flush_o) else $error("flush without resume");
    a_resume_one_cyc: assert property (resume_o |=> !resume_o)
        else $error("resume wider than one cycle");
    a_pdall_all_off: assert property (!pll_en_o ##1 !pll_en_o |->
        !core_clk_en_o && !periph_clk_en_o && core_halt_o)
        else $error("clock running in full power-down");
    a_boot_addr_ok: assert property (start_o |-> start_addr_o ==
        ((boot_mode_o[1:0] != 2'h0) ? 24'hff0000 : 24'h010000))
        else $error("start address wrong");
    a_mask_until_rdy: assert property (!clock_ready_o |->
        stack_reset_o && irq_mask_all_o && core_halt_o)
        else $error("reset state left early");
    a_start_clears: assert property (start_o |-> clock_ready_o ##1
        !start_o ##[0:1] (!stack_reset_o && !irq_mask_all_o))
        else $error("masks kept after start");
    a_ready_after_stab: assert property ($rose(clock_ready_o) |->
        cnt_ff >= STAB_CYCLES - 1 && cnt_ff <= STAB_CYCLES + 2)
        else $error("stabilisation length wrong");
    a_msel_from_strap: assert property ($rose(clock_ready_o) |->
        ##[0:2] pll_msel_o == strap_msel_i)
        else $error("multiplier not taken from straps");
    c_full_wake: cover property (s_pdall_wake);
endmodule : pmc_ctrl_asserts

bind pmc_ctrl pmc_ctrl_asserts #(.STAB_CYCLES(STAB_CYCLES)) pmc_ctrl_asserts_i (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wake_irq_i(wake_irq_i),
    .strap_msel_i(strap_msel_i), .core_clk_en_o(core_clk_en_o),
    .periph_clk_en_o(periph_clk_en_o), .pll_en_o(pll_en_o),
    .core_halt_o(core_halt_o), .pipe_flush_o(pipe_flush_o),
    .resume_o(resume_o), .pll_msel_o(pll_msel_o),
    .stack_reset_o(stack_reset_o), .irq_mask_all_o(irq_mask_all_o),
    .start_o(start_o), .start_addr_o(start_addr_o),
    .boot_mode_o(boot_mode_o), .clock_ready_o(clock_ready_o));

// ===== tb/test_pmc_ctrl.sv
`timescale 1ns/1ps
module test_pmc_ctrl;
    import pmc_pkg::*;
    localparam int STAB = 12;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wait_req, idle_exec, wake_irq, core_en, per_en, pll_en;
    logic        halt, flush, resume, ck_out, start, ready, ser_sel;
    logic [6:0]  msel;
    logic [23:0] start_addr;
    pmc_strap_t  strap = '0;
    pmc_pllcfg_t cfg;
    logic [31:0] exp_q[$];
    int          n_start = 0;
    int          n_mismatch = 0;
    int          checked = 0;
    logic [2:0]  mbits[4] = '{3'h0, 3'h2, 3'h6, 3'h7};
    logic [5:0]  mst[4] = '{6'h02, 6'h04, 6'h08, 6'h10};
    int          lat[4] = '{2, 2, 5, 500};

    pmc_ctrl #(.STAB_CYCLES(STAB)) pmc_ctrl_i (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wait_req), .idle_exec_i(idle_exec),
        .wake_irq_i(wake_irq), .strap_msel_i(strap.msel),
        .strap_bypass_i(strap.bypass), .strap_div_in_i(strap.div_in),
        .strap_sermode_i(strap.sermode), .strap_bmode_i(strap.bmode),
        .bus_req_n_i(strap.bus_req), .core_clk_en_o(core_en),
        .periph_clk_en_o(per_en), .pll_en_o(pll_en), .core_halt_o(halt),
        .pipe_flush_o(flush), .resume_o(resume),
        .periph_clock_output_o(ck_out), .pll_msel_o(msel),
        .pll_bypass_o(), .pll_div_in_o(), .stack_reset_o(),
        .irq_mask_all_o(), .start_o(start), .start_addr_o(start_addr),
        .boot_mode_o(), .serial_select_o(ser_sel), .clock_ready_o(ready));
    pmc_core_model pmc_core_model_i (.clk_i(clk_i),
        .idle_exec_o(idle_exec), .wake_irq_o(wake_irq));

    //------------------------------------------------------------
    // Clock, watchdog and verdict
    //------------------------------------------------------------
    initial forever #5 clk_i = ~clk_i;
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    //------------------------------------------------------------
    // Bus master; a read notes its expected word in the queue
    //------------------------------------------------------------
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        if (!w) exp_q.push_back(d);
        @(posedge clk_i iff wait_req === 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    // Read data and start address watcher
    always @(posedge clk_i) begin
        if (rd && wait_req === 1'b0 && exp_q.size() > 0)
            check(rdat, exp_q.pop_front());
        if (start === 1'b1) begin
            n_start++;
            check(start_addr, (strap.bmode != 2'h0) ? 24'hff0000
                              : 24'h010000);
        end
    end
    // Peripheral ticks and clock-out toggles over c cycles
    task automatic ticks(input int c, output int t, output int g);
        logic p;
        t = 0;
        g = 0;
        p = ck_out;
        repeat (c) begin
            @(negedge clk_i);
            t += (per_en === 1'b1);
            g += (ck_out !== p);
            p = ck_out;
        end
    endtask : ticks
    task automatic do_reset();
        int n;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check({halt, ready}, 2'b10);
        rst_n_i <= 1'b1;
        n = 0;
        while (ready !== 1'b1 && n < 100) begin
            @(negedge clk_i);
            n++;
        end
        check(n >= STAB && n <= STAB + 1, 1'b1);
    endtask : do_reset
    task automatic wait_start(input int k);
        int n;
        n = 0;
        while (n_start < k && n < 20) begin
            @(negedge clk_i);
            n++;
        end
        check(n_start, k);
    endtask : wait_start

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial begin
        int n, t, g;
        void'($urandom(94294));
        strap = pmc_strap_t'($urandom);
        strap.div_in = 1'b0;
        strap.bus_req = 1'b0;
        do_reset();
        check(ser_sel, strap.sermode);
        repeat (6) @(negedge clk_i);
        check(n_start, 0);
        @(posedge clk_i);
        strap.bus_req <= 1'b1;
        wait_start(1);
        cfg = '{strap.bypass, strap.div_in, strap.msel, 1'b0, 1'b0, 1'b0,
                1'b0};
        bus(1'b0, 4'h0, {19'h0, cfg});
        bus(1'b0, 4'hc, (strap.bmode != 2'h0) ? 32'hff0000 : 32'h010000);
        bus(1'b0, 4'h2, 32'h0);
        cfg.msel = 7'($urandom);
        bus(1'b1, 4'h0, {19'h0, cfg});
        bus(1'b0, 4'h0, {19'h0, cfg});
        @(negedge clk_i);
        check(msel, cfg.msel);
        bus(1'b1, 4'h8, {31'h0, !strap.sermode});
        bus(1'b0, 4'h8, {31'h0, !strap.sermode});
        check(ser_sel, !strap.sermode);
        for (int s = 1; s >= 0; s--) begin
            cfg.half_sel = s[0];
            bus(1'b1, 4'h0, {19'h0, cfg});
            repeat (2) @(negedge clk_i);
            ticks(20, t, g);
            check(t, (s == 1) ? 10 : 20);
            check(g, t);
        end
        pmc_core_model_i.do_wake(0);
        n = 0;
        while (resume !== 1'b1 && n < 8) begin
            @(negedge clk_i);
            n++;
        end
        check(n, 8);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 4'h0, {19'h0, cfg[12:3], mbits[m]});
            pmc_core_model_i.do_idle();
            @(negedge clk_i);
            check({core_en, pll_en, halt}, {m == 0, m < 3, 1'b1});
            ticks(4, t, g);
            check(t, (m < 2) ? 4 : 0);
            bus(1'b0, 4'h4, {21'h0, 2'b11, strap.sermode, strap.bmode,
                             mst[m]});
            pmc_core_model_i.do_wake($urandom_range(3));
            n = 0;
            while (resume !== 1'b1 && n < 600) begin
                @(negedge clk_i);
                n++;
            end
            check(n > lat[m] && n <= lat[m] + 1 + (m == 2), 1'b1);
            check({flush, halt}, {m >= 2, 1'b0});
        end
        @(posedge clk_i);
        strap.bmode <= 2'h0;
        do_reset();
        wait_start(2);
        stop_test();
    end
endmodule : test_pmc_ctrl
